/* File: flash_program_erase_controller_test.sv */
// Bench: requester and controller joined over the link, link checker in the bench.
// Assumes erase counts shortened through the controller parameters.
`timescale 1ns/1ps
module flash_program_erase_controller_test;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic v = 1'b0, w = 1'b0, fe = 1'b0;
    logic dbg = 1'b0, hlt = 1'b0;
    logic [31:0] a = 32'h0, d = 32'h0, cfg, wa, wb, x, rd, na, nd;
    logic [1:0] sz = 2'h2, op;
    logic done, refd, flt, busy, stl, st, rdy, pend;
    int bad_count = 0;
    int n_checks = 0;
    fpec_if lk();
    fpec_ctrl #(.PAGE_ERASE_CYC(20), .FULL_ERASE_CYC(40)) i_fpec_ctrl (.i_clk_sys, .i_reset_n, .link(lk),
        .o_nvm_start(st), .o_nvm_op(op), .o_nvm_addr(na), .o_nvm_data(nd), .o_cfg_pending(pend), .o_ready(rdy));
    fpec_host i_fpec_host (.i_clk_sys, .i_reset_n, .link(lk), .i_cmd_valid(v), .i_cmd_we(w), .i_cmd_addr(a),
        .i_cmd_wdata(d), .i_cmd_size(sz), .i_cmd_debug(dbg), .i_cpu_halted(hlt), .i_fetch(fe), .o_done(done),
        .o_refused(refd), .o_fault(flt), .o_rdata(rd), .o_busy(busy), .o_stalled(stl));
    fpec_props i_props (.i_clk_sys, .i_reset_n, .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
        .size(lk.size), .fetch(lk.fetch), .ack(lk.ack), .fault(lk.fault), .stall(lk.stall), .rdata(lk.rdata));
    // ====================
    // Clock and tasks
    // ====================
    initial forever #10 i_clk_sys = ~i_clk_sys;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    function automatic logic [31:0] reg_at(input logic [11:0] o);
        return fpec_pkg::REG_BASE + {20'h0, o};
    endfunction : reg_at
    // One command; k: 0 done, 1 fault, 2 refused; eop: expected array op or -1
    task automatic acc(input logic wv, input logic [31:0] ad, input logic [31:0] dt, input logic [1:0] s,
                       input int k, input int eop, input logic [31:0] ea);
        int got = -1;
        logic seen = 1'b0;
        logic low = 1'b0;
        logic [1:0] sop;
        logic [31:0] sa, sd;
        @(negedge i_clk_sys);
        {v, w, a, d, sz} = {1'b1, wv, ad, dt, s};
        // Refusal answers one cycle on, so sample from the very next edge
        for (int t = 0; t < 3000 && got < 0; t++) begin
            @(negedge i_clk_sys);
            v = 1'b0;
            if (t == 0) chk("busy", busy, k != 2);
            if (st === 1'b1) {seen, sop, sa, sd} = {1'b1, op, na, nd};
            low |= rdy === 1'b0;
            got = done === 1'b1 ? 0 : flt === 1'b1 ? 1 : refd === 1'b1 ? 2 : -1;
        end
        if (got < 0) begin
            bad_count++;
            conclude();
        end
        chk("answer", got, k);
        chk("started", seen, eop >= 0);
        if (eop >= 0) begin
            chk("ready low", low, 1'b1);
            chk("op", sop, eop);
            chk("addr", sa, ea);
            if (eop == 0) chk("data", sd, dt);
        end
    endtask : acc
    // ====================
    // Main sequence
    // ====================
    initial begin
        void'($urandom(32'hA8D2639C));
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        cfg = reg_at(fpec_pkg::OFS_CONFIG);
        wa = $urandom_range(32'h2FFFC) & 32'hFFFFFFFC;
        wb = wa ^ 32'h100;
        x = $urandom;
        // Ignored write goes to another word so the limit count of wa starts clean
        acc(1'b1, wb, x, 2'h2, 0, -1, 32'h0);
        acc(1'b1, cfg, 32'h1, 2'h2, 0, -1, 32'h0);
        acc(1'b1, cfg, 32'h3, 2'h2, 2, -1, 32'h0);
        repeat (2) acc(1'b1, wa, x, 2'h2, 0, 0, wa);
        acc(1'b1, wa, x, 2'h2, 2, -1, 32'h0);
        for (int i = 0; i < 3; i++) acc(1'b1, wb + 32'(i / 2 * 2), x, 2'(i), 1, -1, 32'h0);
        acc(1'b1, fpec_pkg::CFG_BASE + 32'h8, x, 2'h2, 0, 0, fpec_pkg::CFG_BASE + 32'h8);
        chk("pending", pend, 1'b1);
        acc(1'b1, cfg, 32'h2, 2'h2, 0, -1, 32'h0);
        // Debugger erase refused until the CPU is halted
        dbg = 1'b1;
        acc(1'b1, reg_at(fpec_pkg::OFS_PAGE_ERASE), wa & 32'hFFFFF000, 2'h2, 2, -1, 32'h0);
        hlt = 1'b1;
        acc(1'b1, reg_at(fpec_pkg::OFS_PAGE_ERASE), wa & 32'hFFFFF000, 2'h2, 0, 1, wa & 32'hFFFFF000);
        {dbg, hlt} = 2'h0;
        acc(1'b0, reg_at(fpec_pkg::OFS_READY), 32'h0, 2'h2, 0, -1, 32'h0);
        chk("ready busy", rd, 32'h0);
        chk("no stall", stl, 1'b0);
        fe = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk("fetch stall", stl, 1'b1);
        fe = 1'b0;
        repeat (30) @(negedge i_clk_sys);
        acc(1'b0, reg_at(fpec_pkg::OFS_READY), 32'h0, 2'h2, 0, -1, 32'h0);
        chk("ready idle", rd, 32'h1);
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, reg_at(i ? fpec_pkg::OFS_FULL_ERASE : fpec_pkg::OFS_CFG_ERASE), 32'h1, 2'h2, 0, 2 + i,
                i ? fpec_pkg::FLASH_BASE : fpec_pkg::CFG_BASE);
            repeat (50) @(negedge i_clk_sys);
        end
        acc(1'b1, cfg, 32'h0, 2'h2, 0, -1, 32'h0);
        acc(1'b1, reg_at(fpec_pkg::OFS_PAGE_ERASE), 32'h0, 2'h2, 0, -1, 32'h0);
        conclude();
    end
endmodule : flash_program_erase_controller_test

/* File: fpec_ctrl.sv */
// Flash program/erase controller: registers, program and erase sequencing,
// CPU stall, and command strobes to the flash array macro.
// Assumes the macro clears bits where the program data is 0 and never sets any.
//
// Notes on behaviour
// - Program or erase only with its enable
// - Software never sets both enables together
// - Debug halts CPU before starting operations
// - Program only whole aligned 32-bit words
// - Word writes limited before page erase
// - Programming only clears bits, never sets
// - Partial update: unchanged bits written as ones
// - Narrow or unaligned program gives hard fault
// - Word program lasts write time, CPU stalled
// - Page erase trigger erases one page
// - Erase stalls only CPU flash fetches
// - Config words programmed alike, effective after reset
// - Config write limit; CPU stalled during write
// - Config erase sets area to ones
// - Full erase: flash and config, not factory
// - Ready reads 0 busy, 1 idle
`timescale 1ns/1ps
module fpec_ctrl #(
    parameter int PAGE_ERASE_CYC = fpec_pkg::PAGE_ERASE_CYC,
    parameter int FULL_ERASE_CYC = fpec_pkg::FULL_ERASE_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    fpec_if.dev link,
    output logic o_nvm_start,
    output logic [1:0] o_nvm_op,
    output logic [31:0] o_nvm_addr,
    output logic [31:0] o_nvm_data,
    output logic o_cfg_pending,
    output logic o_ready
);
    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [1:0] {
        FPEC_IDLE = 2'h0,
        FPEC_PROG = 2'h1,
        FPEC_ERASE = 2'h2
    } fpec_state_e;

    localparam logic [31:0] WRITE_LOAD = 32'(fpec_pkg::WORD_WRITE_CYC - 1);
    localparam logic [31:0] PAGE_LOAD = 32'(PAGE_ERASE_CYC - 1);
    localparam logic [31:0] FULL_LOAD = 32'(FULL_ERASE_CYC - 1);

    fpec_state_e state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic wen_reg, wen_next;
    logic een_reg, een_next;
    logic ack_reg, ack_next;
    logic fault_reg, fault_next;
    logic stall_reg, stall_next;
    logic [31:0] rdata_reg, rdata_next;
    logic start_reg, start_next;
    logic [1:0] op_reg, op_next;
    logic [31:0] naddr_reg, naddr_next;
    logic [31:0] ndata_reg, ndata_next;
    logic pend_reg, pend_next;
    logic ready_reg, ready_next;

    fpec_pkg::fpec_region_e rgn;
    logic [11:0] ofs;
    logic fresh;
    logic aligned_word;

    assign rgn = fpec_pkg::fpec_region(link.addr);
    assign ofs = link.addr[11:0];
    // Blocks a second take while the host is still dropping its request
    assign fresh = link.req && !ack_reg && !fault_reg;
    assign aligned_word = (link.size == fpec_pkg::SIZE_WORD) && (link.addr[1:0] == 2'h0);

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Request decode, sequencing and register file
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wen_next = wen_reg;
        een_next = een_reg;
        ack_next = 1'b0;
        fault_next = 1'b0;
        rdata_next = rdata_reg;
        start_next = 1'b0;
        op_next = op_reg;
        naddr_next = naddr_reg;
        ndata_next = ndata_reg;
        pend_next = pend_reg;
        unique case (state_reg)
            FPEC_PROG: begin
                if (cnt_reg == 32'h0) begin
                    state_next = FPEC_IDLE;
                    ack_next = 1'b1; // Releases the stalled write
                end else begin
                    cnt_next = cnt_reg - 32'h1;
                end
            end
            FPEC_IDLE, FPEC_ERASE: begin
                if (state_reg == FPEC_ERASE) begin
                    if (cnt_reg == 32'h0) begin
                        state_next = FPEC_IDLE;
                    end else begin
                        cnt_next = cnt_reg - 32'h1;
                    end
                end
                if (fresh && rgn == fpec_pkg::RGN_REGS) begin
                    ack_next = 1'b1;
                    rdata_next = 32'h0;
                    if (!link.we) begin
                        if (ofs == fpec_pkg::OFS_READY) begin
                            rdata_next = {31'h0, state_reg == FPEC_IDLE};
                        end else if (ofs == fpec_pkg::OFS_CONFIG) begin
                            rdata_next = 32'h0;
                            rdata_next[fpec_pkg::CFG_WEN_BIT] = wen_reg;
                            rdata_next[fpec_pkg::CFG_EEN_BIT] = een_reg;
                        end
                    end else if (ofs == fpec_pkg::OFS_CONFIG) begin
                        wen_next = link.wdata[fpec_pkg::CFG_WEN_BIT];
                        een_next = link.wdata[fpec_pkg::CFG_EEN_BIT];
                    end else if (een_reg && state_reg == FPEC_IDLE) begin
                        if (ofs == fpec_pkg::OFS_PAGE_ERASE) begin
                            state_next = FPEC_ERASE;
                            cnt_next = PAGE_LOAD;
                            start_next = 1'b1;
                            op_next = fpec_pkg::OP_PAGE_ERASE;
                            naddr_next = link.wdata;
                        end else if (ofs == fpec_pkg::OFS_CFG_ERASE && link.wdata[fpec_pkg::TRIGGER_BIT]) begin
                            state_next = FPEC_ERASE;
                            cnt_next = PAGE_LOAD;
                            start_next = 1'b1;
                            op_next = fpec_pkg::OP_CFG_ERASE;
                            naddr_next = fpec_pkg::CFG_BASE;
                            pend_next = 1'b1;
                        end else if (ofs == fpec_pkg::OFS_FULL_ERASE && link.wdata[fpec_pkg::TRIGGER_BIT]) begin
                            state_next = FPEC_ERASE;
                            cnt_next = FULL_LOAD;
                            start_next = 1'b1;
                            op_next = fpec_pkg::OP_FULL_ERASE;
                            naddr_next = fpec_pkg::FLASH_BASE;
                            pend_next = 1'b1;
                        end
                    end
                end else if (fresh && link.we && (rgn == fpec_pkg::RGN_FLASH || rgn == fpec_pkg::RGN_CFG)) begin
                    // Memory writes wait out an erase in progress
                    if (state_reg == FPEC_IDLE) begin
                        if (!wen_reg) begin
                            ack_next = 1'b1;
                        end else if (!aligned_word) begin
                            fault_next = 1'b1;
                        end else begin
                            state_next = FPEC_PROG;
                            cnt_next = WRITE_LOAD;
                            start_next = 1'b1;
                            op_next = fpec_pkg::OP_PROGRAM;
                            naddr_next = link.addr;
                            ndata_next = link.wdata;
                            if (rgn == fpec_pkg::RGN_CFG) begin
                                pend_next = 1'b1;
                            end
                        end
                    end
                end else if (fresh && rgn != fpec_pkg::RGN_FLASH && rgn != fpec_pkg::RGN_CFG) begin
                    // Unmapped access answered with zero
                    ack_next = 1'b1;
                    rdata_next = 32'h0;
                end else if (fresh && !link.we) begin
                    // Array reads are served by the array path
                    ack_next = 1'b1;
                    rdata_next = 32'h0;
                end
            end
            default: begin
                state_next = FPEC_IDLE;
            end
        endcase
        // stall all in program, fetches in erase
        stall_next = (state_next == FPEC_PROG) || (state_next == FPEC_ERASE && link.fetch);
        ready_next = (state_next == FPEC_IDLE);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Cleared only by reset, so pending config waits for it
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= FPEC_IDLE;
            cnt_reg <= 32'h0;
            wen_reg <= fpec_pkg::RESET_CONFIG[fpec_pkg::CFG_WEN_BIT];
            een_reg <= fpec_pkg::RESET_CONFIG[fpec_pkg::CFG_EEN_BIT];
            ack_reg <= 1'b0;
            fault_reg <= 1'b0;
            stall_reg <= 1'b0;
            rdata_reg <= 32'h0;
            start_reg <= 1'b0;
            op_reg <= fpec_pkg::OP_PROGRAM;
            naddr_reg <= 32'h0;
            ndata_reg <= 32'hFFFF_FFFF;
            pend_reg <= 1'b0;
            ready_reg <= fpec_pkg::RESET_READY[0];
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wen_reg <= wen_next;
            een_reg <= een_next;
            ack_reg <= ack_next;
            fault_reg <= fault_next;
            stall_reg <= stall_next;
            rdata_reg <= rdata_next;
            start_reg <= start_next;
            op_reg <= op_next;
            naddr_reg <= naddr_next;
            ndata_reg <= ndata_next;
            pend_reg <= pend_next;
            ready_reg <= ready_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign link.ack = ack_reg;
    assign link.fault = fault_reg;
    assign link.stall = stall_reg;
    assign link.rdata = rdata_reg;
    assign o_nvm_start = start_reg;
    assign o_nvm_op = op_reg;
    assign o_nvm_addr = naddr_reg;
    assign o_nvm_data = ndata_reg;
    assign o_cfg_pending = pend_reg;
    assign o_ready = ready_reg;
endmodule : fpec_ctrl

/* File: fpec_host.sv */
// Requester end: turns user commands into link accesses and keeps the
// software-side obligations (enable exclusivity, halt, write limit).
// Assumes one command at a time, issued while o_busy is low.
`timescale 1ns/1ps
module fpec_host (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    fpec_if.host link,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_we,
    input wire logic [31:0] i_cmd_addr,
    input wire logic [31:0] i_cmd_wdata,
    input wire logic [1:0] i_cmd_size,
    input wire logic i_cmd_debug,
    input wire logic i_cpu_halted,
    input wire logic i_fetch,
    output logic o_done,
    output logic o_refused,
    output logic o_fault,
    output logic [31:0] o_rdata,
    output logic o_busy,
    output logic o_stalled
);
    // ==========================================================
    // Write-count tracker
    // ==========================================================
    // Small direct-mapped table; an evicted word restarts its count,
    // trading exactness for size.
    localparam int TRK_N = 8;
    localparam logic [1:0] TRK_MAX = 2'(fpec_pkg::MAX_WRITES_PER_WORD);

    logic [31:0] tag_reg [TRK_N];
    logic [31:0] tag_next [TRK_N];
    logic [1:0] cnt_reg [TRK_N];
    logic [1:0] cnt_next [TRK_N];
    logic req_reg, req_next;
    logic we_reg, we_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [1:0] size_reg, size_next;
    logic fetch_reg, fetch_next;
    logic done_reg, done_next;
    logic refused_reg, refused_next;
    logic fault_reg, fault_next;
    logic [31:0] rdata_reg, rdata_next;
    logic busy_reg, busy_next;
    logic stalled_reg, stalled_next;

    fpec_pkg::fpec_region_e rgn;
    logic [2:0] idx;
    logic mem_wr;
    logic cfg_wr;
    logic erase_wr;
    logic hit;

    assign rgn = fpec_pkg::fpec_region(i_cmd_addr);
    assign idx = i_cmd_addr[4:2];
    assign mem_wr = i_cmd_we && (rgn == fpec_pkg::RGN_FLASH || rgn == fpec_pkg::RGN_CFG);
    assign cfg_wr = i_cmd_we && rgn == fpec_pkg::RGN_REGS && i_cmd_addr[11:0] == fpec_pkg::OFS_CONFIG;
    assign erase_wr = i_cmd_we && rgn == fpec_pkg::RGN_REGS
        && (i_cmd_addr[11:0] == fpec_pkg::OFS_PAGE_ERASE || i_cmd_addr[11:0] == fpec_pkg::OFS_CFG_ERASE
            || i_cmd_addr[11:0] == fpec_pkg::OFS_FULL_ERASE);
    assign hit = tag_reg[idx] == i_cmd_addr;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Command acceptance, refusal and completion
    always_comb begin
        tag_next = tag_reg;
        cnt_next = cnt_reg;
        req_next = req_reg;
        we_next = we_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        size_next = size_reg;
        done_next = 1'b0;
        refused_next = 1'b0;
        fault_next = 1'b0;
        rdata_next = rdata_reg;
        busy_next = busy_reg;
        fetch_next = i_fetch;
        stalled_next = link.stall;
        if (req_reg && (link.ack || link.fault)) begin
            req_next = 1'b0;
            busy_next = 1'b0;
            done_next = link.ack;
            fault_next = link.fault;
            rdata_next = link.rdata;
        end else if (i_cmd_valid && !busy_reg) begin
            if (cfg_wr && i_cmd_wdata[fpec_pkg::CFG_WEN_BIT] && i_cmd_wdata[fpec_pkg::CFG_EEN_BIT]) begin
                refused_next = 1'b1;
            end else if (i_cmd_debug && !i_cpu_halted && (mem_wr || erase_wr)) begin
                refused_next = 1'b1;
            end else if (mem_wr && hit && cnt_reg[idx] >= TRK_MAX) begin
                refused_next = 1'b1;
            end else begin
                req_next = 1'b1;
                busy_next = 1'b1;
                we_next = i_cmd_we;
                addr_next = i_cmd_addr;
                wdata_next = i_cmd_wdata;
                size_next = i_cmd_size;
                if (mem_wr) begin
                    tag_next[idx] = i_cmd_addr;
                    cnt_next[idx] = hit ? cnt_reg[idx] + 2'h1 : 2'h1;
                end
                // Any erase write resets all counts; lenient for page erase
                if (erase_wr) begin
                    for (int k = 0; k < TRK_N; k++) begin
                        cnt_next[k] = 2'h0;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Link drive and user answers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int k = 0; k < TRK_N; k++) begin
                tag_reg[k] <= 32'hFFFF_FFFF;
                cnt_reg[k] <= 2'h0;
            end
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            addr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            size_reg <= fpec_pkg::SIZE_WORD;
            fetch_reg <= 1'b0;
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            fault_reg <= 1'b0;
            rdata_reg <= 32'h0;
            busy_reg <= 1'b0;
            stalled_reg <= 1'b0;
        end else begin
            tag_reg <= tag_next;
            cnt_reg <= cnt_next;
            req_reg <= req_next;
            we_reg <= we_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            size_reg <= size_next;
            fetch_reg <= fetch_next;
            done_reg <= done_next;
            refused_reg <= refused_next;
            fault_reg <= fault_next;
            rdata_reg <= rdata_next;
            busy_reg <= busy_next;
            stalled_reg <= stalled_next;
        end
    end

    assign link.req = req_reg;
    assign link.we = we_reg;
    assign link.addr = addr_reg;
    assign link.wdata = wdata_reg;
    assign link.size = size_reg;
    assign link.fetch = fetch_reg;
    assign o_done = done_reg;
    assign o_refused = refused_reg;
    assign o_fault = fault_reg;
    assign o_rdata = rdata_reg;
    assign o_busy = busy_reg;
    assign o_stalled = stalled_reg;
endmodule : fpec_host

/* File: fpec_if.sv */
// Link between the CPU/debug requester and the flash controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface fpec_if;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic fetch;
    logic ack;
    logic fault;
    logic stall;
    logic [31:0] rdata;

    modport dev (input req, input we, input addr, input wdata, input size, input fetch,
                 output ack, output fault, output stall, output rdata);
    modport host (output req, output we, output addr, output wdata, output size, output fetch,
                  input ack, input fault, input stall, input rdata);
endinterface : fpec_if

/* File: fpec_pkg.sv */
// Package for the flash program/erase controller and its requester.
// Assumes a single 50 MHz system clock shared by both ends.
package fpec_pkg;
    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 20;
    // Word write time and erase times; values are plain defaults
    localparam int WORD_WRITE_TIME_NS = 40000;
    localparam int PAGE_ERASE_TIME_NS = 2000000;
    localparam int FULL_ERASE_TIME_NS = 4000000;
    localparam int WORD_WRITE_CYC = (WORD_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ERASE_CYC = (PAGE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FULL_ERASE_CYC = (FULL_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_WRITES_PER_WORD = 2;

    // ==========================================================
    // Address map
    // ==========================================================
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_SIZE = 32'h0003_0000;
    localparam logic [31:0] CFG_BASE = 32'h1000_1000;
    localparam logic [31:0] CFG_SIZE = 32'h0000_1000;
    localparam logic [31:0] REG_BASE = 32'h4001_E000;
    localparam logic [31:0] REG_SIZE = 32'h0000_1000;
    localparam logic [11:0] OFS_READY = 12'h400;
    localparam logic [11:0] OFS_CONFIG = 12'h504;
    localparam logic [11:0] OFS_PAGE_ERASE = 12'h508;
    localparam logic [11:0] OFS_FULL_ERASE = 12'h50C;
    localparam logic [11:0] OFS_CFG_ERASE = 12'h514;
    localparam int CFG_WEN_BIT = 0;
    localparam int CFG_EEN_BIT = 1;
    localparam int TRIGGER_BIT = 0;
    localparam logic [31:0] RESET_READY = 32'h0000_0001;
    localparam logic [31:0] RESET_CONFIG = 32'h0000_0000;

    // ==========================================================
    // Encodings
    // ==========================================================
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } fpec_size_e;

    typedef enum logic [1:0] {
        OP_PROGRAM = 2'h0,
        OP_PAGE_ERASE = 2'h1,
        OP_CFG_ERASE = 2'h2,
        OP_FULL_ERASE = 2'h3
    } fpec_op_e;

    typedef enum logic [1:0] {
        RGN_NONE = 2'h0,
        RGN_FLASH = 2'h1,
        RGN_CFG = 2'h2,
        RGN_REGS = 2'h3
    } fpec_region_e;

    // Region decode shared by both ends
    function automatic fpec_region_e fpec_region(input logic [31:0] addr);
        if (addr - FLASH_BASE < FLASH_SIZE) begin
            return RGN_FLASH;
        end else if (addr - CFG_BASE < CFG_SIZE) begin
            return RGN_CFG;
        end else if (addr - REG_BASE < REG_SIZE) begin
            return RGN_REGS;
        end
        return RGN_NONE;
    endfunction : fpec_region
endpackage : fpec_pkg

/* File: fpec_props.sv */
// Link checker for the requester and flash controller pair.
// Assumes it sits beside the link interface, same clock and reset.
`timescale 1ns/1ps
module fpec_props (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [1:0] size,
    input wire logic fetch,
    input wire logic ack,
    input wire logic fault,
    input wire logic stall,
    input wire logic [31:0] rdata
);
    // ====================
    // Stall run length
    // ====================
    int cnt_reg;
    int cnt_next;
    // Length of the current stall run, so a word write can be timed
    always_comb cnt_next = stall ? cnt_reg + 1 : 0;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) cnt_reg <= 0;
        else cnt_reg <= cnt_next;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack held too long");
    a_fault_one_pulse: assert property (fault |=> !fault) else $error("fault held too long");
    a_answer_excl: assert property (!(ack && fault)) else $error("ack and fault together");
    a_answer_has_req: assert property ((ack || fault) |-> $past(req)) else $error("answer without request");
    a_req_held_stable: assert property (req && !ack && !fault |=> req && $stable(addr) && $stable(wdata))
        else $error("request dropped or changed");
    a_req_release: assert property ((ack || fault) |=> !req) else $error("request not released");
    a_fault_cause: assert property (fault |-> $past(we) && ($past(size) != 2'h2 || $past(addr) % 4 != 0))
        else $error("fault on aligned word");
    a_write_time: assert property ($fell(stall) && ack |-> cnt_reg == fpec_pkg::WORD_WRITE_CYC)
        else $error("word write stall length wrong");
    a_no_ack_writing: assert property (stall && !fetch && !$past(fetch) |-> !ack)
        else $error("answer during word write");
    a_rdata_held: assert property ($changed(rdata) |-> ack) else $error("read data changed without ack");
    c_fault: cover property (fault);
    c_fetch_stall: cover property (stall && fetch);
    c_word_write: cover property ($fell(stall) && ack);
endmodule : fpec_props
